// ### common/aosc_defs.svh
// register offsets, field positions, reset values and table encodings
`ifndef AOSC_DEFS_SVH
`define AOSC_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define AOSC_PWR_MODE_OFS   8'h2b
`define AOSC_INT_WAKE_OFS   8'h2c

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define AOSC_PWR_MODE_RST   8'h00
`define AOSC_INT_WAKE_RST   8'h00
`define AOSC_OSR_RST        11'h080

// ------------------------------------------------------------
// power_mode_reg fields
// ------------------------------------------------------------
`define AOSC_SMODS_HI       4
`define AOSC_SMODS_LO       3
`define AOSC_SLPE_BIT       2
`define AOSC_MODS_HI        1
`define AOSC_MODS_LO        0
`define AOSC_PWR_USED_MASK  8'h1f

// ------------------------------------------------------------
// int_wake_reg fields
// ------------------------------------------------------------
`define AOSC_FIFO_GATE_BIT  7
`define AOSC_WAKE_TRAN_BIT  6
`define AOSC_WAKE_ORNT_BIT  5
`define AOSC_WAKE_PULS_BIT  4
`define AOSC_WAKE_FFMT_BIT  3
`define AOSC_WAKE_VECM_BIT  2
`define AOSC_IPOL_BIT       1
`define AOSC_DRIVE_BIT      0

// ------------------------------------------------------------
// output rate index, ascending from 1.5625 hz to 800 hz
// ------------------------------------------------------------
`define AOSC_RATE_1P5625    3'h0
`define AOSC_RATE_800       3'h7

`endif

// ### common/aosc_pkg.sv
// types shared by the oversampling and auto-sleep control block
package aosc_pkg;

    typedef enum logic [1:0] {
        osr_normal = 2'b00,
        osr_lnlp   = 2'b01,
        osr_hires  = 2'b10,
        osr_lowpwr = 2'b11
    } aosc_osr_mode_t;

    typedef enum logic {
        sys_wake  = 1'b0,
        sys_sleep = 1'b1
    } aosc_sys_mode_t;

endpackage : aosc_pkg

// ### hw/aosc_osr_lut.sv
// oversampling ratio lookup from oversampling mode and output rate index
`timescale 1ns/100ps

module aosc_osr_lut
    import aosc_pkg::*;
(
    input  aosc_osr_mode_t i_mode,
    input  wire logic [2:0] i_rate,
    output logic [10:0]     o_osr
);

    // ------------------------------------------------------------
    // tables, entry 7 (800 hz) first down to entry 0 (1.5625 hz)
    // ------------------------------------------------------------
    localparam logic [7:0][10:0] TBL_NORMAL = {
        11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h010, 11'h020, 11'h080
    };
    localparam logic [7:0][10:0] TBL_LNLP = {
        11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h004, 11'h008, 11'h020
    };
    localparam logic [7:0][10:0] TBL_HIRES = {
        11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h080, 11'h100, 11'h400
    };
    localparam logic [7:0][10:0] TBL_LOWPWR = {
        11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h010
    };

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    always_comb begin
        case (i_mode)
            osr_normal: o_osr = TBL_NORMAL[i_rate]; // RULE6
            osr_lnlp:   o_osr = TBL_LNLP[i_rate];   // RULE7
            osr_hires:  o_osr = TBL_HIRES[i_rate];  // RULE7
            osr_lowpwr: o_osr = TBL_LOWPWR[i_rate]; // RULE6
            default:    o_osr = TBL_NORMAL[i_rate];
        endcase
    end

endmodule : aosc_osr_lut

// ### hw/aosc_ctrl.sv
// auto-sleep, oversampling mode and interrupt pin control of the accelerometer
//
// Function
// RULE1 - bit 2 of the power mode register enables auto-sleep when 1 and disables it when 0.
// RULE2 - with auto-sleep on, each sleep/wake change flushes the sample fifo and resets function counters; the code skips the flush while fifo gate is set.
// RULE3 - function block status is kept unchanged across a sleep/wake change.
// RULE4 - bits 1 to 0 pick the wake oversampling mode, which with the wake rate sets the ratio.
// RULE5 - both mode fields decode 00 normal, 01 low noise low power, 10 high resolution, 11 low power.
// RULE6 - normal and low power modes use their fixed ratio per output rate.
// RULE7 - high resolution and low noise low power modes use their fixed ratio per output rate.
// RULE8 - the register at 2ch holds fifo gate, five wake enables, polarity and drive type from bit 7 down.
// RULE9 - every bit of the 2ch register resets to 0 and is readable and writable.
// RULE10 - bits 4 to 3 pick the sleep oversampling mode, used with the sleep rate.
// RULE11 - with fifo gate set a change keeps the fifo, blocks samples until emptied, and flags an early sample.
// RULE12 - the polarity bit makes both interrupt pins active low at 0 and active high at 1.
// RULE13 - the drive bit makes both interrupt pins push-pull at 0 and open-drain at 1.
// RULE14 - with auto-sleep off the device stays awake and converts with the wake settings only.
`timescale 1ns/100ps
`include "aosc_defs.svh"

module aosc_ctrl
    import aosc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    input  wire logic       i_sleep_req,
    input  wire logic       i_wake_req,
    input  wire logic [2:0] i_wake_rate_select,
    input  wire logic [2:0] i_sleep_rate_select,
    input  wire logic       i_sample_valid,
    input  wire logic       i_fifo_empty,
    input  wire logic       i_irq_one_evt,
    input  wire logic       i_irq_two_evt,
    output logic            o_system_mode_status,
    output logic [10:0]     o_oversampling_ratio,
    output logic            o_fifo_flush,
    output logic            o_counter_reset,
    output logic            o_fifo_block,
    output logic            o_gate_error,
    output logic [4:0]      o_wake_enable,
    output logic            o_irq_pin_one_out,
    output logic            o_irq_pin_one_oe,
    output logic            o_irq_pin_two_out,
    output logic            o_irq_pin_two_oe
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]     power_mode_q;
    logic [7:0]     int_wake_q;
    aosc_sys_mode_t mode_q;
    aosc_sys_mode_t mode_d;
    logic           trans_d;
    logic           slpe_q;
    logic           fifo_gate_q;
    logic           ipol_q;
    logic           drive_od_q;
    aosc_osr_mode_t active_mode;
    logic [2:0]     active_rate;
    logic [10:0]    osr_lut;

    assign slpe_q      = power_mode_q[`AOSC_SLPE_BIT];
    assign fifo_gate_q = int_wake_q[`AOSC_FIFO_GATE_BIT];
    assign ipol_q      = int_wake_q[`AOSC_IPOL_BIT];
    assign drive_od_q  = int_wake_q[`AOSC_DRIVE_BIT];

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            power_mode_q <= `AOSC_PWR_MODE_RST;
        end else if (i_reg_wr && i_reg_addr == `AOSC_PWR_MODE_OFS) begin
            power_mode_q <= i_reg_wdata & `AOSC_PWR_USED_MASK; // RULE1
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            int_wake_q <= `AOSC_INT_WAKE_RST; // RULE9
        end else if (i_reg_wr && i_reg_addr == `AOSC_INT_WAKE_OFS) begin
            int_wake_q <= i_reg_wdata; // RULE8
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `AOSC_PWR_MODE_OFS: o_reg_rdata <= power_mode_q;
                `AOSC_INT_WAKE_OFS: o_reg_rdata <= int_wake_q; // RULE9
                default:            o_reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_wake_enable <= 5'h00;
        end else begin
            o_wake_enable <= int_wake_q[`AOSC_WAKE_TRAN_BIT:`AOSC_WAKE_VECM_BIT]; // RULE8
        end
    end

    // ------------------------------------------------------------
    // sleep / wake state
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            sys_wake: begin
                if (slpe_q && i_sleep_req) begin
                    mode_d = sys_sleep;
                end
            end
            sys_sleep: begin
                if (!slpe_q || i_wake_req) begin
                    mode_d = sys_wake; // RULE14
                end
            end
            default: mode_d = sys_wake;
        endcase
    end

    // forced wake on auto-sleep disable is not an auto-sleep transition
    assign trans_d = slpe_q && (mode_d != mode_q);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            mode_q <= sys_wake;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_system_mode_status <= 1'b0;
        end else begin
            o_system_mode_status <= (mode_d == sys_sleep);
        end
    end

    // ------------------------------------------------------------
    // flush, counter reset and fifo gate
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_fifo_flush    <= 1'b0;
            o_counter_reset <= 1'b0;
        end else begin
            o_fifo_flush    <= trans_d && !fifo_gate_q; // RULE2
            o_counter_reset <= trans_d;                 // RULE2
        end
    end

    // fifo block is set by a gated transition; the gate error flag is left alone by a transition
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_fifo_block <= 1'b0;
        end else if (trans_d && fifo_gate_q) begin
            o_fifo_block <= 1'b1; // RULE11
        end else if (i_fifo_empty) begin
            o_fifo_block <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_gate_error <= 1'b0;
        end else if (o_fifo_block && i_sample_valid) begin
            o_gate_error <= 1'b1; // RULE11
        end else if (i_fifo_empty) begin
            o_gate_error <= 1'b0; // RULE3
        end
    end

    // ------------------------------------------------------------
    // oversampling ratio
    // ------------------------------------------------------------
    always_comb begin
        if (mode_q == sys_sleep) begin
            active_mode = aosc_osr_mode_t'(power_mode_q[`AOSC_SMODS_HI:`AOSC_SMODS_LO]); // RULE10
            active_rate = i_sleep_rate_select;
        end else begin
            active_mode = aosc_osr_mode_t'(power_mode_q[`AOSC_MODS_HI:`AOSC_MODS_LO]); // RULE4
            active_rate = i_wake_rate_select;
        end
    end

    aosc_osr_lut u_osr_lut (
        .i_mode (active_mode), // RULE5
        .i_rate (active_rate),
        .o_osr  (osr_lut)
    );

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_oversampling_ratio <= `AOSC_OSR_RST;
        end else begin
            o_oversampling_ratio <= osr_lut;
        end
    end

    // ------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_irq_pin_one_out <= 1'b1;
            o_irq_pin_one_oe  <= 1'b1;
            o_irq_pin_two_out <= 1'b1;
            o_irq_pin_two_oe  <= 1'b1;
        end else if (drive_od_q) begin
            // open-drain only pulls low
            o_irq_pin_one_out <= 1'b0;
            o_irq_pin_one_oe  <= !(i_irq_one_evt == ipol_q); // RULE13
            o_irq_pin_two_out <= 1'b0;
            o_irq_pin_two_oe  <= !(i_irq_two_evt == ipol_q); // RULE13
        end else begin
            o_irq_pin_one_out <= (i_irq_one_evt == ipol_q); // RULE12
            o_irq_pin_one_oe  <= 1'b1;
            o_irq_pin_two_out <= (i_irq_two_evt == ipol_q); // RULE12
            o_irq_pin_two_oe  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    slpe_bit_write_a: assert property ( // RULE1
        i_reg_wr && i_reg_addr == `AOSC_PWR_MODE_OFS |=> slpe_q == $past(i_reg_wdata[`AOSC_SLPE_BIT]))
        else $error("auto-sleep bit not taken from bit 2");

    stay_awake_a: assert property ( // RULE14
        !slpe_q |=> mode_q == sys_wake && !o_counter_reset)
        else $error("left wake mode with auto-sleep off");

    trans_flush_a: assert property ( // RULE2
        trans_d && !fifo_gate_q |=> o_fifo_flush && o_counter_reset && mode_q != $past(mode_q))
        else $error("transition without flush and counter reset");

    gated_keep_a: assert property ( // RULE11
        trans_d && fifo_gate_q |=> !o_fifo_flush && o_fifo_block)
        else $error("gated transition flushed or did not block");

    gate_error_set_a: assert property ( // RULE11
        o_fifo_block && i_sample_valid |=> o_gate_error [*1] ##0 $rose(o_gate_error) || $past(o_gate_error))
        else $error("gate error not raised by blocked sample");

    status_kept_a: assert property ( // RULE3
        o_gate_error && !i_fifo_empty |=> o_gate_error)
        else $error("gate error lost without fifo empty");

    hires_slow_a: assert property ( // RULE7
        mode_q == sys_wake && power_mode_q[1:0] == 2'b10 && i_wake_rate_select == `AOSC_RATE_1P5625
        |=> o_oversampling_ratio == 11'h400)
        else $error("high resolution ratio at slowest rate wrong");

    sleep_lowpwr_a: assert property ( // RULE10
        mode_q == sys_sleep && power_mode_q[4:3] == 2'b11 && i_sleep_rate_select == `AOSC_RATE_1P5625
        |=> o_oversampling_ratio == 11'h010)
        else $error("sleep low power ratio wrong");

    normal_fast_a: assert property ( // RULE6
        mode_q == sys_wake && power_mode_q[1:0] == 2'b00 && i_wake_rate_select == `AOSC_RATE_800
        |=> o_oversampling_ratio == 11'h002)
        else $error("normal ratio at fastest rate wrong");

    reg_readback_a: assert property ( // RULE9
        i_reg_wr && i_reg_addr == `AOSC_INT_WAKE_OFS
        ##1 !i_reg_wr
        ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == `AOSC_INT_WAKE_OFS)
        |=> o_reg_rdata == $past(i_reg_wdata, 3))
        else $error("interrupt wake register readback mismatch");

    push_pull_low_a: assert property ( // RULE12
        !drive_od_q && !ipol_q && i_irq_one_evt |=> o_irq_pin_one_oe && !o_irq_pin_one_out)
        else $error("active low push-pull pin not driven low");

    open_drain_a: assert property ( // RULE13
        drive_od_q && ipol_q && !i_irq_two_evt |=> o_irq_pin_two_oe && !o_irq_pin_two_out)
        else $error("open-drain inactive high pin not pulled low");

    forced_wake_a: assert property ( // RULE14
        mode_q == sys_sleep && !slpe_q |=> mode_q == sys_wake && !o_fifo_flush && !o_counter_reset)
        else $error("forced wake flushed or kept sleep");

    block_clear_a: assert property ( // RULE11
        o_fifo_block && i_fifo_empty && !(trans_d && fifo_gate_q) |=> !o_fifo_block)
        else $error("fifo block not released when fifo empty");

    enter_sleep_c: cover property (mode_q == sys_wake ##1 mode_q == sys_sleep);
    wake_flush_c:  cover property (mode_q == sys_sleep ##1 o_fifo_flush);
    gated_c:       cover property (o_fifo_block ##1 i_fifo_empty ##1 !o_fifo_block);
    gate_error_c:  cover property ($rose(o_gate_error));
    forced_wake_c: cover property (mode_q == sys_sleep && !slpe_q);

endmodule : aosc_ctrl

// ### verif/aosc_fifo_model.sv
// behavioural sample fifo beside the control block
`timescale 1ns/100ps

module aosc_fifo_model (
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    input  wire logic i_sample_valid,
    input  wire logic i_fifo_flush,
    input  wire logic i_fifo_block,
    input  wire logic i_drain,
    output logic      o_fifo_empty
);
    logic [5:0] level_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            level_q <= 6'h00;
        end else if (i_fifo_flush || i_drain) begin
            level_q <= 6'h00;
        end else if (i_sample_valid && !i_fifo_block && level_q != 6'h20) begin
            level_q <= level_q + 6'h01;
        end
    end

    assign o_fifo_empty = (level_q == 6'h00);
endmodule : aosc_fifo_model

// ### verif/test_accel_osr_autosleep_ctrl.sv
// self-checking bench of the auto-sleep and oversampling control block
`timescale 1ns/100ps
`include "aosc_defs.svh"

module test_accel_osr_autosleep_ctrl
    import aosc_pkg::*;
;
    logic clk, rst_b, wr, rd, slp, wak, smp, drain, ev1, ev2, empty;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] wrate, srate;
    logic stat, flush, ctr, blk, gerr, p1, e1, p2, e2;
    logic [10:0] osr;
    logic [4:0] wen;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] tab [4] = '{32'h75422221, 32'h53222221, 32'ha8754321, 32'h42111111};

    aosc_ctrl DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sleep_req(slp), .i_wake_req(wak),
        .i_wake_rate_select(wrate), .i_sleep_rate_select(srate), .i_sample_valid(smp),
        .i_fifo_empty(empty), .i_irq_one_evt(ev1), .i_irq_two_evt(ev2), .o_system_mode_status(stat),
        .o_oversampling_ratio(osr), .o_fifo_flush(flush), .o_counter_reset(ctr), .o_fifo_block(blk),
        .o_gate_error(gerr), .o_wake_enable(wen), .o_irq_pin_one_out(p1), .o_irq_pin_one_oe(e1),
        .o_irq_pin_two_out(p2), .o_irq_pin_two_oe(e2));

    aosc_fifo_model fifo (.i_core_clk(clk), .i_rst_b(rst_b), .i_sample_valid(smp), .i_fifo_flush(flush),
        .i_fifo_block(blk), .i_drain(drain), .o_fifo_empty(empty));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [10:0] ex, input logic [10:0] got);
        cmp_count++;
        if (got !== ex) begin
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
            n_errors++;
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) begin
            addr  <= a;
            wdata <= v;
            wr    <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk) begin
            addr <= a;
            rd   <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic trans(input logic to_sleep);
        @(posedge clk) begin
            slp <= to_sleep;
            wak <= !to_sleep;
        end
        @(posedge clk) begin
            slp <= 1'b0;
            wak <= 1'b0;
        end
        #1;
    endtask : trans

    task automatic pulse_in(input logic is_drain);
        @(posedge clk) if (is_drain) drain <= 1'b1; else smp <= 1'b1;
        @(posedge clk) begin
            drain <= 1'b0;
            smp   <= 1'b0;
        end
        #1;
    endtask : pulse_in

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, wr, rd, slp, wak, smp, drain, ev1, ev2} = '0;
        {addr, wdata, wrate, srate} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk) #1;
        chk("osr_rst", 11'h080, osr);
        chk("irq_rst", 11'h00f, {7'h00, p1, e1, p2, e2});
        rd_reg(`AOSC_INT_WAKE_OFS, d);
        chk("iw_rst", 11'h000, {3'h0, d});
        wr_reg(`AOSC_INT_WAKE_OFS, 8'hff);
        rd_reg(`AOSC_INT_WAKE_OFS, d);
        chk("iw_ff", 11'h0ff, {3'h0, d});
        rd_reg(8'h2d, d);
        chk("unmapped", 11'h000, {3'h0, d});
        wr_reg(`AOSC_INT_WAKE_OFS, 8'h28);
        @(posedge clk) #1;
        chk("wake_en", 11'h00a, {6'h00, wen});
        wr_reg(`AOSC_PWR_MODE_OFS, 8'hff);
        rd_reg(`AOSC_PWR_MODE_OFS, d);
        chk("pwr_rb", 11'h01f, {3'h0, d});
        wr_reg(`AOSC_PWR_MODE_OFS, 8'h18);
        wr_reg(`AOSC_INT_WAKE_OFS, 8'h00);
        trans(1'b1);
        chk("no_sleep", 11'h000, {8'h00, stat, flush, ctr});
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 8; r++) begin
                wr_reg(`AOSC_PWR_MODE_OFS, {3'h3, 3'h0, m[1:0]});
                @(posedge clk) wrate <= r[2:0];
                repeat (3) @(posedge clk);
                #1 chk("osr_wake", 11'h001 << tab[m][(7-r)*4 +: 4], osr);
            end
        end
        wr_reg(`AOSC_PWR_MODE_OFS, 8'h14);
        @(posedge clk) begin
            srate <= 3'h1;
            wrate <= 3'h7;
        end
        trans(1'b1);
        chk("to_sleep", 11'h007, {8'h00, stat, flush, ctr});
        repeat (2) @(posedge clk);
        #1 chk("osr_sleep", 11'h100, osr);
        wr_reg(`AOSC_PWR_MODE_OFS, 8'h1c);
        @(posedge clk) srate <= 3'h0;
        repeat (2) @(posedge clk);
        #1 chk("osr_slp_lp", 11'h010, osr);
        trans(1'b0);
        chk("to_wake", 11'h003, {8'h00, stat, flush, ctr});
        repeat (2) @(posedge clk);
        #1 chk("osr_back", 11'h002, osr);
        wr_reg(`AOSC_INT_WAKE_OFS, 8'h80);
        pulse_in(1'b0);
        trans(1'b1);
        chk("gate_trans", 11'h00b, {7'h00, stat, flush, ctr, blk});
        pulse_in(1'b0);
        chk("gate_err", 11'h003, {9'h000, blk, gerr});
        pulse_in(1'b1);
        @(posedge clk) #1;
        chk("gate_clr", 11'h000, {9'h000, blk, gerr});
        for (int i = 0; i < 8; i++) begin
            wr_reg(`AOSC_INT_WAKE_OFS, {6'h00, i[2], i[1]});
            @(posedge clk) begin
                ev1 <= i[0];
                ev2 <= !i[0];
            end
            repeat (2) @(posedge clk);
            #1;
            chk("oe_one", {10'h000, i[1] ? (i[2] ^ i[0]) : 1'b1}, {10'h000, e1});
            chk("oe_two", {10'h000, i[1] ? (i[2] ^ !i[0]) : 1'b1}, {10'h000, e2});
            if (i[1] == 1'b0) begin
                chk("pp_one", {10'h000, !(i[2] ^ i[0])}, {10'h000, p1});
                chk("pp_two", {10'h000, (i[2] ^ i[0])}, {10'h000, p2});
            end else begin
                chk("od_one", 11'h000, {10'h000, p1});
                chk("od_two", 11'h000, {10'h000, p2});
            end
        end
        chk("asleep", 11'h001, {10'h000, stat});
        wr_reg(`AOSC_PWR_MODE_OFS, 8'h00);
        @(posedge clk) #1;
        chk("forced_wake", 11'h000, {8'h00, stat, flush, ctr});
        stop_test();
    end
endmodule : test_accel_osr_autosleep_ctrl
